// >>> common/isr_pkg.sv
// ==========================================================================
// shared constants and types for the upper interrupt status block
package status_pkg;

  // ========================================================================
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LANES = 4;

  // ========================================================================
  // register byte offsets
  localparam logic [7:0] COMMAND_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] MASK_OFFSET = 8'h14;

  // ========================================================================
  // status bit positions
  localparam int BIT_TX_RESET_DONE = 25;
  localparam int BIT_RX_RESET_DONE = 24;
  localparam int BIT_PARITY_ERROR_SEEN = 23;
  localparam int BIT_SYSTEM_ERROR_SIGNALED = 22;
  localparam int BIT_MASTER_ABORT_RECEIVED = 21;
  localparam int BIT_TARGET_ABORT_RECEIVED = 20;
  localparam int BIT_RX_STATUS_QUEUE_OVERFLOW = 16;
  localparam int BIT_HIGH_ERROR_SUMMARY = 15;
  localparam int BIT_PHY_REQUEST = 14;
  localparam int BIT_POWER_WAKE_EVENT = 13;
  localparam int BIT_SOFTWARE_EVENT = 12;
  localparam int BIT_STATISTICS_SERVICE = 11;
  localparam int BIT_TX_UNDERRUN = 10;
  localparam int BIT_TX_WENT_IDLE = 9;
  localparam int BIT_TX_PACKET_FAILED = 8;
  localparam int SUMMARY_LO = 16;
  localparam int SUMMARY_HI = 25;

  // command register field
  localparam int BIT_SOFTWARE_REQUEST = 7;

  // ========================================================================
  // field masks and reset values
  localparam logic [31:0] STATUS_LATCHED = 32'h03f1_7f00;
  localparam logic [31:0] STATUS_READABLE = 32'h03f1_ff00;
  localparam logic [31:0] STATUS_RESET = 32'h0300_0000;
  localparam logic [31:0] MASK_WRITABLE = 32'h03f1_ff00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // ========================================================================
  // event sources from the engines around the block
  typedef struct packed {
    logic txResetDone;
    logic rxResetDone;
    logic parityErrorSeen;
    logic systemErrorSignaled;
    logic masterAbortReceived;
    logic targetAbortReceived;
    logic rxStatusQueueOverflow;
    logic phyRequest;
    logic powerWakeEvent;
    logic statisticsService;
    logic txUnderrun;
    logic tx_went_idle;
    logic txPacketFailed;
  } event_in_t;

  // top level state
  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
    logic [31:0] mask;
    logic swPulse;
    logic intLine;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{ack: 1'b0, rdData: 32'h0000_0000, mask: MASK_RESET,
                                       swPulse: 1'b0, intLine: 1'b0};

endpackage

// >>> verilog/rise_detect.sv
`timescale 1ns/1ps
// ==========================================================================
// rising edge detector on a group of level flags
module rise_detect #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // levels in, one-cycle pulses out
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // next copy of the previous level
  always_comb begin
    prev_d = level;
  end

  // history register, reset to the expected idle levels
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_q <= INIT;
    end else begin
      prev_q <= prev_d;
    end
  end

  // pulse when a level goes from low to high
  assign rise = level & ~prev_q;

endmodule

// >>> verilog/event_latch.sv
`timescale 1ns/1ps
// ==========================================================================
// sticky event bits, cleared all at once, set beats clear
module event_latch #(
  parameter int W = 32,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // set and clear
  input wire logic [W-1:0] setVec,
  input wire logic clearAll,
  // latched bits
  output logic [W-1:0] bits
);

  logic [W-1:0] bits_q;
  logic [W-1:0] bits_d;

  // clear drops old bits, new events still land
  always_comb begin
    bits_d = clearAll ? '0 : bits_q;
    bits_d = (bits_d | setVec) & VALID;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bits_q <= INIT & VALID;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign bits = bits_q;

endmodule

// >>> verilog/interrupt_status_upper.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
// ==========================================================================
// upper interrupt status word with mask and interrupt line
module interrupt_status_upper
  import status_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [LANES-1:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // event sources
  input wire event_in_t eventIn,
  // interrupt request, active high
  output logic intLine
);

  // ========================================================================
  // declarations
  top_state_t state_q;
  top_state_t state_d;
  logic access;
  logic readClr;
  logic [7:0] wordAddr;
  logic [31:0] setVec;
  logic [31:0] statusQ;
  logic [31:0] statusWord;
  logic [1:0] riseVec;
  logic [31:0] readMux;
  logic [31:0] enabledBits;
  logic [31:0] eventBits;

  // ========================================================================
  // bus decode
  // a request is taken once, ack drops the cycle after it rose
  assign access = wb_cyc_i && wb_stb_i && !state_q.ack;
  assign wordAddr = {wb_adr_i[ADDR_W-1:2], 2'b00};

  // a read of the status word clears it at the answering edge
  assign readClr = access && !wb_we_i && (wordAddr == STATUS_OFFSET);

  // ========================================================================
  // edge detection for level sources
  // idle history starts high so the first idle after reset is not an event
  rise_detect #(
    .W(2),
    .INIT(2'b10)
  ) u_rise (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .level({eventIn.tx_went_idle, eventIn.parityErrorSeen}),
    .rise(riseVec)
  );

  // ========================================================================
  // event vector, one bit per status position
  always_comb begin
    setVec = 32'h0000_0000;
    setVec[BIT_TX_RESET_DONE] = eventIn.txResetDone;
    setVec[BIT_RX_RESET_DONE] = eventIn.rxResetDone;
    setVec[BIT_PARITY_ERROR_SEEN] = riseVec[0];
    setVec[BIT_SYSTEM_ERROR_SIGNALED] = eventIn.systemErrorSignaled;
    setVec[BIT_MASTER_ABORT_RECEIVED] = eventIn.masterAbortReceived;
    setVec[BIT_TARGET_ABORT_RECEIVED] = eventIn.targetAbortReceived;
    setVec[BIT_RX_STATUS_QUEUE_OVERFLOW] = eventIn.rxStatusQueueOverflow;
    setVec[BIT_PHY_REQUEST] = eventIn.phyRequest;
    setVec[BIT_POWER_WAKE_EVENT] = eventIn.powerWakeEvent;
    setVec[BIT_SOFTWARE_EVENT] = state_q.swPulse;
    setVec[BIT_STATISTICS_SERVICE] = eventIn.statisticsService;
    setVec[BIT_TX_UNDERRUN] = eventIn.txUnderrun;
    setVec[BIT_TX_WENT_IDLE] = riseVec[1];
    setVec[BIT_TX_PACKET_FAILED] = eventIn.txPacketFailed;
  end

  // ========================================================================
  // sticky status bits
  // no mask term here: masking only gates the line
  event_latch #(
    .W(32),
    .VALID(STATUS_LATCHED),
    .INIT(STATUS_RESET)
  ) u_latch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .setVec(setVec),
    .clearAll(readClr),
    .bits(statusQ)
  );

  // summary bit is derived, never stored
  always_comb begin
    statusWord = statusQ & STATUS_READABLE;
    statusWord[BIT_HIGH_ERROR_SUMMARY] = |statusQ[SUMMARY_HI:SUMMARY_LO];
  end

  // ========================================================================
  // read data selection
  // unmapped words and the command word read as zero
  always_comb begin
    readMux = 32'h0000_0000;
    case (wordAddr)
      STATUS_OFFSET: begin
        readMux = statusWord;
      end
      MASK_OFFSET: begin
        readMux = state_q.mask;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  // ========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    state_d.ack = access;
    state_d.swPulse = 1'b0;
    // line follows enabled pending bits one cycle later
    state_d.intLine = |(statusWord & state_q.mask);
    if (access) begin
      if (wb_we_i) begin
        case (wordAddr)
          MASK_OFFSET: begin
            for (int lane = 0; lane < LANES; lane++) begin
              if (wb_sel_i[lane]) begin
                state_d.mask[lane*8 +: 8] = wb_dat_i[lane*8 +: 8] & MASK_WRITABLE[lane*8 +: 8];
              end
            end
          end
          COMMAND_OFFSET: begin
            // request bit is self clearing, raises one event
            state_d.swPulse = wb_sel_i[0] && wb_dat_i[BIT_SOFTWARE_REQUEST];
          end
          default: begin
            // status writes and unmapped writes are dropped
            state_d.swPulse = 1'b0;
          end
        endcase
      end else begin
        state_d.rdData = readMux;
      end
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= TOP_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs come straight from the state register
  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.rdData;
  assign intLine = state_q.intLine;

  // ========================================================================
  // check helpers
  // enabled pending bits and new events, sampled by the checks below
  assign enabledBits = statusWord & state_q.mask;
  assign eventBits = setVec & STATUS_LATCHED;

  // ========================================================================
  // checks
  // line tracks enabled pending bits
  line_follows_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> intLine == |$past(enabledBits))
    else $error("interrupt line does not match enabled pending bits");

  // events latch even with every mask bit off
  latch_unmasked_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventBits != 32'h0 |=> (statusQ & $past(eventBits)) == $past(eventBits))
    else $error("event not latched");

  // a clearing read with no new events empties the status
  read_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    readClr && setVec == 32'h0 |=> statusQ == 32'h0 ##1 (statusQ == 32'h0 || $past(setVec) != 32'h0))
    else $error("status read did not clear the bits");

  // read answer carries the pending bits seen at the taking edge
  read_data_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    readClr |=> wb_ack_o && wb_dat_o == $past(statusWord))
    else $error("status read returned wrong data");

  // a write to status keeps every bit
  write_ignored_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && wb_we_i && wordAddr == STATUS_OFFSET |=> (statusQ & $past(statusQ)) == $past(statusQ))
    else $error("status write changed a bit");

  // parity flag going high lands in bit 23
  parity_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(eventIn.parityErrorSeen) |=> statusQ[BIT_PARITY_ERROR_SEEN])
    else $error("parity error not reported");

  // summary bit mirrors the high group
  summary_or_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    statusWord[BIT_HIGH_ERROR_SUMMARY] == (statusWord[SUMMARY_HI:SUMMARY_LO] != 10'h000))
    else $error("summary bit wrong");

  // software request reaches bit 12 two edges after the write
  software_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && wb_we_i && wordAddr == COMMAND_OFFSET && wb_sel_i[0] && wb_dat_i[BIT_SOFTWARE_REQUEST]
    |=> state_q.swPulse ##1 statusQ[BIT_SOFTWARE_EVENT])
    else $error("software event not reported");

  // busy to idle transition lands in bit 9
  tx_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && $rose(eventIn.tx_went_idle) |=> statusQ[BIT_TX_WENT_IDLE])
    else $error("transmit idle not reported");

  // mask and line are clear after reset
  mask_reset_a: assert property (@(posedge core_clk)
    $past(sys_rst) && !sys_rst |-> state_q.mask == 32'h0 && !intLine ##1 !intLine)
    else $error("mask or line not cleared by reset");

  // event colliding with a clearing read survives
  set_wins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    readClr |=> statusQ == ($past(setVec) & STATUS_LATCHED))
    else $error("event lost during clearing read");

  // reserved positions stay zero
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (statusWord & ~STATUS_READABLE) == 32'h0 && (state_q.mask & ~MASK_WRITABLE) == 32'h0)
    else $error("reserved bit set");

  // ack is a single cycle answer to a taken request
  ack_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one cycle answer");

  // transmit reset completion lands in bit 25
  tx_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.txResetDone |=> statusQ[BIT_TX_RESET_DONE])
    else $error("transmit reset completion not reported");

  // receive reset completion lands in bit 24
  rx_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.rxResetDone |=> statusQ[BIT_RX_RESET_DONE])
    else $error("receive reset completion not reported");

  // signaled system error lands in bit 22
  system_error_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.systemErrorSignaled |=> statusQ[BIT_SYSTEM_ERROR_SIGNALED])
    else $error("system error not reported");

  // master abort lands in bit 21
  master_abort_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.masterAbortReceived |=> statusQ[BIT_MASTER_ABORT_RECEIVED])
    else $error("master abort not reported");

  // target abort lands in bit 20
  target_abort_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.targetAbortReceived |=> statusQ[BIT_TARGET_ABORT_RECEIVED])
    else $error("target abort not reported");

  // receive status queue overflow lands in bit 16
  status_overflow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.rxStatusQueueOverflow |=> statusQ[BIT_RX_STATUS_QUEUE_OVERFLOW])
    else $error("status queue overflow not reported");

  // transceiver request lands in bit 14
  phy_request_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.phyRequest |=> statusQ[BIT_PHY_REQUEST])
    else $error("transceiver request not reported");

  // wake condition lands in bit 13
  wake_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.powerWakeEvent |=> statusQ[BIT_POWER_WAKE_EVENT])
    else $error("wake event not reported");

  // statistics threshold lands in bit 11
  stats_service_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.statisticsService |=> statusQ[BIT_STATISTICS_SERVICE])
    else $error("statistics service not reported");

  // transmit underrun lands in bit 10
  tx_underrun_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.txUnderrun |=> statusQ[BIT_TX_UNDERRUN])
    else $error("transmit underrun not reported");

  // failed transmit write-back lands in bit 8
  tx_failed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    eventIn.txPacketFailed |=> statusQ[BIT_TX_PACKET_FAILED])
    else $error("transmit failure not reported");

  // a status write adds nothing beyond new events
  write_adds_nothing_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && wb_we_i && wordAddr == STATUS_OFFSET |=> statusQ == ($past(statusQ) | $past(eventBits)))
    else $error("status write set a bit");

  // line drops two edges after a clean clearing read
  read_drops_line_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    readClr && setVec == 32'h0 |-> ##2 !intLine)
    else $error("interrupt line held after clearing read");

  // closed mask keeps the line low
  mask_closed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q.mask == 32'h0 |=> !intLine)
    else $error("interrupt line high with mask closed");

  // full mask write keeps only writable bits
  mask_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && wb_we_i && wordAddr == MASK_OFFSET && wb_sel_i == 4'hf |=> state_q.mask == ($past(wb_dat_i) & MASK_WRITABLE))
    else $error("mask write wrong");

  // mask read returns the stored mask
  read_mask_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    access && !wb_we_i && wordAddr == MASK_OFFSET |=> wb_dat_o == $past(state_q.mask))
    else $error("mask read wrong");

endmodule

// >>> sim/event_engines.sv
`timescale 1ns/1ps
// ==========================================================================
// model of the engines that raise status events
module event_engines
  import status_pkg::*;
(
  // clock
  input wire logic core_clk,
  // one-cycle requests from the bench, same order as event_in_t
  input wire logic [12:0] fireReq,
  // event lines toward the status block
  output event_in_t eventIn
);
  // transmit engine rests idle, a request makes it busy for one cycle
  always @(posedge core_clk) begin
    eventIn <= event_in_t'(fireReq ^ 13'h0002);
  end
endmodule

// >>> sim/test_interrupt_status_upper.sv
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the upper interrupt status block
module test_interrupt_status_upper
  import status_pkg::*;
;
  localparam int MAX_WAIT = 20;
  localparam int POS [13] = '{25, 24, 23, 22, 21, 20, 16, 14, 13, 11, 10, 9, 8};
  logic core_clk, sys_rst, wbWe, wbCyc, wbStb, wbAck, intLine;
  logic [ADDR_W-1:0] wbAdr;
  logic [DATA_W-1:0] wbDatW, wbDatR;
  logic [LANES-1:0] wbSel;
  logic [12:0] fireReq, f;
  event_in_t eventIn;
  logic [31:0] rng, rd, exp, maskV;
  int errors, checksDone;

  // ========================================================================
  // design and event source model
  interrupt_status_upper DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .eventIn(eventIn), .intLine(intLine));
  event_engines engines (.core_clk(core_clk), .fireReq(fireReq), .eventIn(eventIn));

  // ========================================================================
  // expectation helpers
  function automatic logic [31:0] status_of(input logic [12:0] ev);
    logic [31:0] s = '0;
    for (int i = 0; i < 13; i++) begin
      if (ev[12-i]) s[POS[i]] = 1'b1;
    end
    if (|s[25:16]) s[15] = 1'b1;
    return s;
  endfunction

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // compare and count
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // counts and verdict
  task automatic final_report;
    $display("counts: %0d checks, %0d mismatches", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] q);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    wbSel <= 4'hf;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < MAX_WAIT);
    if (wbAck !== 1'b1) begin
      errors++;
      $display("mismatch wb_ack expected 1 seen %b", wbAck);
      final_report;
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge core_clk);
  endtask

  // one-cycle event request
  task automatic fire(input logic [12:0] ev);
    fireReq <= ev;
    @(posedge core_clk);
    fireReq <= '0;
  endtask

  // ========================================================================
  // clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ========================================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {wbWe, wbCyc, wbStb} = 3'h0;
    wbAdr = '0;
    wbDatW = '0;
    wbSel = '0;
    fireReq = '0;
    errors = 0;
    checksDone = 0;
    rng = 32'd47916;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    // reset values, then read clears
    chk("intLine", 32'h0, {31'h0, intLine});
    wb_cycle(1'b0, MASK_OFFSET, 32'h0, rd);
    chk("mask", MASK_RESET, rd);
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'h0300_8000, rd);
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'h0, rd);
    $display("test reset done");
    // every source alone with the mask closed, status writes in between
    for (int i = 0; i < 13; i++) begin
      fire(13'h0001 << i);
      repeat (6) @(posedge core_clk);
      chk("intLine", 32'h0, {31'h0, intLine});
      wb_cycle(1'b1, STATUS_OFFSET, 32'hffff_ffff, rd);
      wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
      chk("status", status_of(13'h0001 << i), rd);
    end
    $display("test sources done");
    // software request through the command register
    wb_cycle(1'b1, COMMAND_OFFSET, 32'h0000_0080, rd);
    repeat (4) @(posedge core_clk);
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'h0000_1000, rd);
    $display("test software done");
    // event in the very cycle the clearing read is taken
    fireReq <= 13'h0800;
    @(posedge core_clk);
    fireReq <= '0;
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'h0, rd);
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", status_of(13'h0800), rd);
    $display("test collision done");
    // random masks and event groups
    for (int k = 0; k < 24; k++) begin
      rng = xorshift(rng);
      maskV = rng & MASK_WRITABLE;
      rng = xorshift(rng);
      f = rng[12:0];
      exp = status_of(f);
      wb_cycle(1'b1, MASK_OFFSET, maskV, rd);
      fire(f);
      repeat (6) @(posedge core_clk);
      chk("intLine", {31'h0, |(exp & maskV)}, {31'h0, intLine});
      wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
      chk("status", exp, rd);
      wb_cycle(1'b0, MASK_OFFSET, 32'h0, rd);
      chk("mask", maskV, rd);
      repeat (2) @(posedge core_clk);
      chk("intLine", 32'h0, {31'h0, intLine});
    end
    $display("test random done");
    // mid-run reset with the mask open and a bit pending
    wb_cycle(1'b1, MASK_OFFSET, 32'hffff_ffff, rd);
    fire(13'h0001);
    repeat (4) @(posedge core_clk);
    chk("intLine", 32'h1, {31'h0, intLine});
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("intLine", 32'h0, {31'h0, intLine});
    wb_cycle(1'b0, MASK_OFFSET, 32'h0, rd);
    chk("mask", MASK_RESET, rd);
    wb_cycle(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'h0300_8000, rd);
    $display("test second reset done");
    final_report;
  end
endmodule
